//--- rtl/lsd_pkg.sv
// constants shared by the led sink driver device end and its host end
// assumes one 40 MHz system clock shared by both ends
package lsd_pkg;
    localparam int          CLK_PERIOD_NS   = 25;
    localparam int          NUM_CH          = 8;
    localparam int          KEY_LEN         = 5;
    // mode keys: enable_mode_pin_n and latch_mode_pin, cycle 1 in bit 0
    localparam logic [4:0]  KEY_EN_N        = 5'h1d;  // H L H H H
    localparam logic [4:0]  KEY_LE_ENTER    = 5'h08;  // L L L H L
    localparam logic [4:0]  KEY_LE_RESUME   = 5'h00;  // L L L L L
    localparam int          EN_LOW_MIN_CYC  = 2;
    localparam int          RESTART_CYC     = 3;
    localparam int          DETECT_TIME_NS  = 2000;
    localparam int          DETECT_CYC      = (DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  ALL_ON          = 8'hff;
    // host command codes
    localparam logic [1:0]  CMD_WRITE       = 2'h0;
    localparam logic [1:0]  CMD_DETECT      = 2'h1;
    localparam logic [1:0]  CMD_BLANK       = 2'h2;
endpackage

//--- rtl/lsd_if.sv
// pin bundle between the led sink driver and its host
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface lsd_if (
    input wire logic clock
);
    logic serial_in;
    logic serial_out;
    logic latch_mode_pin;
    logic enable_mode_pin_n;
    modport device (input clock, input serial_in, input latch_mode_pin, input enable_mode_pin_n, output serial_out);
    modport host   (input clock, output serial_in, output latch_mode_pin, output enable_mode_pin_n, input serial_out);
endinterface

//--- rtl/lsd_device.sv
// led sink driver device end: shift register, latch, mode key detector, detection
// assumes host keeps its timing duties; channel faults arrive as sensed flags
`timescale 1ns/1ps
module lsd_device
    import lsd_pkg::*;
(
    lsd_if.device                   pins,
    input  wire logic               reset,
    input  wire logic [7:0]         current_low,
    input  wire logic [7:0]         voltage_high,
    output logic      [7:0]         channel_on,
    output logic                    detect_mode
);
    import lsd_pkg::*;

    typedef enum logic [1:0] {
        LSD_NORMAL = 2'b01,
        LSD_DETECT = 2'b10
    } lsd_mode_t;

    lsd_mode_t          mode_q;
    logic [7:0]         shift_q;
    logic [7:0]         store_q;
    logic [7:0]         fault_q;
    logic [2:0]         key_cnt_q;
    logic               key_le_ok_q;
    logic               key_en_ok_q;
    logic               key_enter_q;
    logic               was_low_q;
    logic               serial_out_q;
    logic               key_done;

    ////////////////////////////////////////////////////////////////////////
    // key tracker: cycle index only; mode_q picks which latch key is compared
    function automatic logic key_bit(input logic [4:0] key, input logic [2:0] idx);
        key_bit = key[idx];
    endfunction

    wire logic en_ok = pins.enable_mode_pin_n == key_bit(KEY_EN_N, key_cnt_q);
    wire logic le_in = pins.latch_mode_pin;
    wire logic le_ok = (mode_q == LSD_NORMAL) ? le_in == key_bit(KEY_LE_ENTER, key_cnt_q)
                                              : le_in == key_bit(KEY_LE_RESUME, key_cnt_q);
    assign key_done = en_ok && le_ok && key_cnt_q == 3'(KEY_LEN - 1);

    always_ff @(posedge pins.clock) begin
        if (reset) begin
            key_cnt_q <= 3'h0;
        end else if (key_done || !(en_ok && le_ok)) begin
            // a mismatch restarts; a mismatching high could open a new key
            key_cnt_q <= (!key_done && pins.enable_mode_pin_n && key_cnt_q != 3'h0 &&
                          !le_in) ? 3'h1 : 3'h0;
        end else begin
            key_cnt_q <= key_cnt_q + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode: keys alternate because each key is only matched in its own mode
    always_ff @(posedge pins.clock) begin
        if (reset) begin
            mode_q <= LSD_NORMAL;
        end else if (key_done) begin
            case (mode_q)
                LSD_NORMAL: mode_q <= LSD_DETECT;
                LSD_DETECT: mode_q <= LSD_NORMAL;
                default:    mode_q <= LSD_NORMAL;
            endcase
        end
    end
    assign detect_mode = mode_q == LSD_DETECT;

    ////////////////////////////////////////////////////////////////////////
    // shift and storage; key cycles after the first do not shift so data starts at edge six
    always_ff @(posedge pins.clock) begin
        if (reset) begin
            shift_q <= 8'h00;
        end else if (detect_mode && was_low_q && pins.enable_mode_pin_n) begin
            shift_q <= fault_q;  // results loaded when enable returns high
        end else if (key_cnt_q == 3'h0 || !(en_ok && le_ok)) begin
            shift_q <= {shift_q[6:0], pins.serial_in};
        end
    end

    always_ff @(posedge pins.clock) begin
        if (reset) begin
            store_q <= 8'h00;
        end else if (le_in && !(en_ok && le_ok)) begin
            // the high latch step of the entry key must not load storage
            store_q <= shift_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // detection: evaluated while enable is low in detection mode
    always_ff @(posedge pins.clock) begin
        if (reset) begin
            fault_q   <= 8'h00;
            was_low_q <= 1'b0;
        end else begin
            was_low_q <= detect_mode && !pins.enable_mode_pin_n;
            if (detect_mode && !pins.enable_mode_pin_n) begin
                fault_q <= store_q & (current_low | voltage_high);
            end
        end
    end

    // limitation: host must give two cycles of enable low
    assign channel_on = pins.enable_mode_pin_n ? 8'h00 : store_q;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(negedge pins.clock) begin
        if (reset) begin
            serial_out_q <= 1'b0;
        end else begin
            serial_out_q <= shift_q[7];
        end
    end
    assign pins.serial_out = serial_out_q;
endmodule

//--- rtl/lsd_host.sv
// host end: sends frames, mode keys, detection run, and reads results
// assumes device end on the same clock; commands buffered two deep
`timescale 1ns/1ps
module lsd_host
    import lsd_pkg::*;
(
    lsd_if.host                     pins,
    input  wire logic               reset,
    input  wire logic               cmd_valid,
    output logic                    cmd_ready,
    input  wire logic [1:0]         cmd_op,
    input  wire logic [7:0]         cmd_data,
    output logic                    res_valid,
    input  wire logic               res_ready,
    output logic      [7:0]         res_data
);
    import lsd_pkg::*;

    typedef enum logic [5:0] {
        LSH_IDLE  = 6'b000001,
        LSH_SHIFT = 6'b000010,
        LSH_LATCH = 6'b000100,
        LSH_ENABLE= 6'b001000,
        LSH_KEY   = 6'b010000,
        LSH_READ  = 6'b100000
    } lsh_state_t;

    lsh_state_t         st_q;
    logic [9:0]         buf_q [2];
    logic [1:0]         cnt_q;
    logic               wr_q;
    logic               rd_q;
    logic [7:0]         data_q;
    logic [1:0]         op_q;
    logic [7:0]         cyc_q;
    logic [2:0]         key_q;
    logic               sin_q;
    logic               le_q;
    logic               en_n_q;
    logic               res_v_q;
    logic [7:0]         res_q;

    ////////////////////////////////////////////////////////////////////////
    // two-entry command buffer, stalls the source when full
    wire logic take = st_q == LSH_IDLE && cnt_q != 2'h0 && !res_v_q;
    wire logic push = cmd_valid && cmd_ready;
    assign cmd_ready = cnt_q != 2'h2;

    always_ff @(posedge pins.clock) begin
        if (reset) begin
            cnt_q <= 2'h0;
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
        end else begin
            if (push) begin
                buf_q[wr_q] <= {cmd_op, cmd_data};
                wr_q        <= ~wr_q;
            end
            if (take) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + 2'(push) - 2'(take);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write: shift 8, latch, enable five cycles; detect: key, all-ones frame,
    // enable for the detection time, read results, resume key
    always_ff @(posedge pins.clock) begin
        if (reset) begin
            st_q    <= LSH_IDLE;
            cyc_q   <= 8'h00;
            key_q   <= 3'h0;
            data_q  <= 8'h00;
            op_q    <= CMD_WRITE;
            sin_q   <= 1'b0;
            le_q    <= 1'b0;
            en_n_q  <= 1'b1;
            res_v_q <= 1'b0;
            res_q   <= 8'h00;
        end else begin
            if (res_v_q && res_ready) begin
                res_v_q <= 1'b0;
            end
            case (st_q)
                LSH_IDLE: begin
                    le_q   <= 1'b0;
                    en_n_q <= 1'b1;
                    if (take) begin
                        op_q   <= buf_q[rd_q][9:8];
                        data_q <= buf_q[rd_q][7:0];
                        cyc_q  <= 8'h00;
                        key_q  <= 3'h0;
                        st_q   <= (buf_q[rd_q][9:8] == CMD_DETECT) ? LSH_KEY : LSH_SHIFT;
                    end
                end
                LSH_KEY: begin
                    // keys sent in pairs, never two alike
                    en_n_q <= KEY_EN_N[key_q];
                    le_q   <= (op_q == CMD_DETECT) ? KEY_LE_ENTER[key_q] : KEY_LE_RESUME[key_q];
                    key_q  <= key_q + 3'h1;
                    if (key_q == 3'(KEY_LEN - 1)) begin
                        st_q <= (op_q == CMD_DETECT) ? LSH_SHIFT : LSH_IDLE;
                        if (op_q == CMD_DETECT) begin
                            data_q <= ALL_ON;
                        end
                    end
                end
                LSH_SHIFT: begin
                    le_q   <= 1'b0;
                    en_n_q <= 1'b1;
                    sin_q  <= data_q[7];
                    data_q <= {data_q[6:0], 1'b0};
                    cyc_q  <= cyc_q + 8'h01;
                    if (cyc_q == 8'(NUM_CH - 1)) begin
                        st_q <= LSH_LATCH;
                    end
                end
                LSH_LATCH: begin
                    le_q  <= 1'b1;
                    cyc_q <= 8'h00;
                    st_q  <= (op_q == CMD_BLANK) ? LSH_IDLE : LSH_ENABLE;
                end
                LSH_ENABLE: begin
                    le_q   <= 1'b0;
                    en_n_q <= 1'b0;
                    cyc_q  <= cyc_q + 8'h01;
                    // clock never stops here, so holds by construction
                    // enable stays low for exactly the count, one cycle over DETECT_CYC in detection
                    if (cyc_q == 8'((op_q == CMD_DETECT) ? DETECT_CYC + 1 : EN_LOW_MIN_CYC + RESTART_CYC)) begin
                        en_n_q <= 1'b1;
                        cyc_q  <= 8'h00;
                        st_q   <= (op_q == CMD_DETECT) ? LSH_READ : LSH_IDLE;
                    end
                end
                LSH_READ: begin
                    cyc_q <= cyc_q + 8'h01;
                    // device loads results on the first high edge; top bit stands from its falling edge
                    if (cyc_q >= 8'h01) begin
                        res_q <= {res_q[6:0], pins.serial_out};
                    end
                    if (cyc_q == 8'(NUM_CH)) begin
                        res_v_q <= 1'b1;
                        op_q    <= CMD_WRITE;
                        key_q   <= 3'h0;
                        st_q    <= LSH_KEY;  // resume after all bits
                    end
                end
                default: st_q <= LSH_IDLE;
            endcase
        end
    end

    assign pins.serial_in        = sin_q;
    assign pins.latch_mode_pin    = le_q;
    assign pins.enable_mode_pin_n = en_n_q;
    assign res_valid             = res_v_q;
    assign res_data              = res_q;
endmodule

//--- bench/lsd_asserts.sv
// checker on the pins between the host end and the device end
// assumes it is instantiated beside the pin bundle in the bench top
`timescale 1ns/1ps
module lsd_asserts
    import lsd_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic latch_mode_pin,
    input wire logic enable_mode_pin_n
);
    import lsd_pkg::*;
    logic [4:0] en_h_q;
    logic [4:0] le_h_q;
    logic [7:0] sin_h_q;
    logic [7:0] low_q;
    logic [7:0] since_q;
    logic       mode_q;
    logic       so_q;
    logic       key_in;
    logic       key_out;
    logic       det_end;
    ////////////////////////////////////////////////////////////////////////////
    assign key_in  = (en_h_q == KEY_EN_N) && (le_h_q == KEY_LE_ENTER);
    assign key_out = (en_h_q == KEY_EN_N) && (le_h_q == KEY_LE_RESUME);
    // a low run longer than one cycle in detection mode is the detection run
    assign det_end = mode_q && enable_mode_pin_n && (low_q > 8'h01);
    always_ff @(posedge clock) begin
        if (reset) begin
            en_h_q <= 5'h1f;
            le_h_q <= 5'h00;
        end else begin
            en_h_q <= {enable_mode_pin_n, en_h_q[4:1]};
            le_h_q <= {latch_mode_pin, le_h_q[4:1]};
        end
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            mode_q <= 1'b0;
        end else if (key_in || key_out) begin
            mode_q <= key_in;
        end
    end
    always_ff @(posedge clock) begin
        sin_h_q <= {sin_h_q[6:0], serial_in};
        so_q    <= serial_out;
    end
    // counters saturate so long idle spans never wrap into a false pass
    always_ff @(posedge clock) begin
        if (reset || enable_mode_pin_n) begin
            low_q <= 8'h00;
        end else if (low_q != 8'hff) begin
            low_q <= low_q + 8'h01;
        end
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            since_q <= 8'hff;
        end else if (det_end) begin
            since_q <= 8'h01;
        end else if (since_q != 8'hff) begin
            since_q <= since_q + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_key_pulse;
        @(posedge clock) disable iff (reset)
        enable_mode_pin_n && $past(enable_mode_pin_n, 2) && !$past(enable_mode_pin_n)
            |-> ##1 enable_mode_pin_n ##1 enable_mode_pin_n;
    endproperty
    a_key_pulse: assert property (p_key_pulse) else $error("one-cycle enable pulse not a key");
    property p_key_latch;
        @(posedge clock) disable iff (reset)
        enable_mode_pin_n && $past(enable_mode_pin_n, 2) && !$past(enable_mode_pin_n)
            |-> !$past(latch_mode_pin, 2) && !$past(latch_mode_pin) && !latch_mode_pin ##2 !latch_mode_pin;
    endproperty
    a_key_latch: assert property (p_key_latch) else $error("latch level wrong in key");
    property p_alternate;
        @(posedge clock) disable iff (reset)
        (key_in || key_out) |-> (key_in != mode_q);
    endproperty
    a_alternate: assert property (p_alternate) else $error("two equal keys in a row");
    property p_ones;
        @(posedge clock) disable iff (reset)
        mode_q && latch_mode_pin |-> sin_h_q == ALL_ON;
    endproperty
    a_ones: assert property (p_ones) else $error("detection latch without all ones");
    property p_det_len;
        @(posedge clock) disable iff (reset)
        det_end |-> low_q >= DETECT_CYC;
    endproperty
    a_det_len: assert property (p_det_len) else $error("detection run too short");
    property p_resume_gap;
        @(posedge clock) disable iff (reset)
        key_out |-> since_q >= (NUM_CH + KEY_LEN);
    endproperty
    a_resume_gap: assert property (p_resume_gap) else $error("resume before results shifted");
    property p_le_pulse;
        @(posedge clock) disable iff (reset)
        $rose(latch_mode_pin) |=> !latch_mode_pin;
    endproperty
    a_le_pulse: assert property (p_le_pulse) else $error("latch pulse longer than one cycle");
    property p_so_edge;
        @(negedge clock) disable iff (reset)
        serial_out == so_q;
    endproperty
    a_so_edge: assert property (p_so_edge) else $error("serial output moved on rising edge");
endmodule

//--- bench/led_sink_error_detect_mode_test.sv
// bench joining host end and device end through the pin bundle
// assumes one 40 MHz clock; inputs change on falling edges
`timescale 1ns/1ps
module led_sink_error_detect_mode_test;
    import lsd_pkg::*;
    logic       clock;
    logic       reset;
    logic       cmd_valid;
    logic       cmd_ready;
    logic       res_valid;
    logic       res_ready;
    logic       detect_mode;
    logic [1:0] cmd_op;
    logic [7:0] cmd_data;
    logic [7:0] res_data;
    logic [7:0] current_low;
    logic [7:0] voltage_high;
    logic [7:0] channel_on;
    int         mismatches;
    int         n_compared;
    lsd_if i_lsd_if (.clock(clock));
    lsd_device i_lsd_device (.pins(i_lsd_if), .reset(reset), .current_low(current_low),
        .voltage_high(voltage_high), .channel_on(channel_on), .detect_mode(detect_mode));
    lsd_host i_lsd_host (.pins(i_lsd_if), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_data(cmd_data), .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
    lsd_asserts i_lsd_asserts (.clock(clock), .reset(reset), .serial_in(i_lsd_if.serial_in),
        .serial_out(i_lsd_if.serial_out), .latch_mode_pin(i_lsd_if.latch_mode_pin),
        .enable_mode_pin_n(i_lsd_if.enable_mode_pin_n));
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_bit(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v && n < lim) begin
            @(negedge clock);
            n++;
        end
        check({7'h00, s}, {7'h00, v});
    endtask
    task automatic wait_ch(input logic [7:0] exp, input int lim);
        int n;
        n = 0;
        while (channel_on !== exp && n < lim) begin
            @(negedge clock);
            n++;
        end
        check(channel_on, exp);
    endtask
    task automatic send(input logic [1:0] op, input logic [7:0] data);
        wait_bit(cmd_ready, 1'b1, 400);
        cmd_valid = 1'b1;
        cmd_op    = op;
        cmd_data  = data;
        @(negedge clock);
        cmd_valid = 1'b0;
        // one idle cycle so a following send never re-raises valid in this step
        @(negedge clock);
    endtask
    task automatic get_res(input logic [7:0] exp);
        wait_bit(res_valid, 1'b1, 600);
        check(res_data, exp);
        res_ready = 1'b1;
        @(negedge clock);
        res_ready = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_write_blank;
        send(CMD_WRITE, 8'ha5);
        wait_ch(8'ha5, 40);
        wait_ch(8'h00, 40);
        send(CMD_BLANK, 8'h3c);
        repeat (30) begin
            @(negedge clock);
            check(channel_on, 8'h00);
        end
        check({7'h00, detect_mode}, 8'h00);
    endtask
    // result stalled while two commands queue up behind it
    task automatic t_detect_stall;
        current_low  = 8'h81;
        voltage_high = 8'h10;
        send(CMD_DETECT, 8'h00);
        wait_bit(detect_mode, 1'b1, 60);
        wait_ch(ALL_ON, 200);
        wait_bit(res_valid, 1'b1, 400);
        send(CMD_WRITE, 8'h0f);
        send(CMD_WRITE, 8'h3c);
        repeat (3) @(negedge clock);
        check({7'h00, cmd_ready}, 8'h00);
        check({7'h00, res_valid}, 8'h01);
        get_res(8'h91);
        wait_bit(detect_mode, 1'b0, 60);
        wait_ch(8'h0f, 60);
        wait_ch(8'h3c, 60);
    endtask
    task automatic t_two_detect;
        current_low  = 8'h00;
        voltage_high = 8'h00;
        send(CMD_DETECT, 8'h00);
        send(CMD_DETECT, 8'h00);
        get_res(8'h00);
        get_res(8'h00);
        wait_bit(detect_mode, 1'b0, 60);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        end_of_test();
    end
    initial begin
        mismatches   = 0;
        n_compared   = 0;
        reset        = 1'b1;
        cmd_valid    = 1'b0;
        cmd_op       = CMD_WRITE;
        cmd_data     = 8'h00;
        res_ready    = 1'b0;
        current_low  = 8'h00;
        voltage_high = 8'h00;
        repeat (20) @(negedge clock);
        reset = 1'b0;
        t_write_blank();
        t_detect_stall();
        t_two_detect();
        end_of_test();
    end
endmodule
